/* File: inc/sct_defs.svh */
// constants for the command-timing link between memory controller and dram end
// Operation
// - loop off: strobe window at latency sum minus one
// - reads only while the loop is locked
// - wait loop exit time after latency change
// - times become clock counts, rounded up; refresh intervals rounded down
// - auto precharge waits for row active time
// - loop off: write recovery max of 4CK, 15ns
// - recovery starts four, or two, after write latency
// - refresh every 64ms, 32ms when hot
// - nine refreshes within every 70.3us
// - back to back refresh bursts are accepted
// - power-down after refresh delay and loop exit
// - one idle cycle between two refreshes
// - slow clock: precharge all after refresh
// - hold device reset low from power ramp
`ifndef SCT_DEFS_SVH
`define SCT_DEFS_SVH

`define SCT_MCLK_PS 100000
`define SCT_CK_DIV 8
`define SCT_TCK_PS (`SCT_MCLK_PS * `SCT_CK_DIV)
`define SCT_CEIL_CK(t) (((t) + `SCT_TCK_PS - 1) / `SCT_TCK_PS)
`define SCT_FLOOR_CK(t) ((t) / `SCT_TCK_PS)
`define SCT_MAX(a, b) (((a) > (b)) ? (a) : (b))

`define SCT_ADDR_W 12
`define SCT_MR_CL_MSB 3
`define SCT_MR_CL_LSB 0
`define SCT_MR_AL_MSB 5
`define SCT_MR_AL_LSB 4
`define SCT_MR_BC4_FIXED 6
`define SCT_MR_LOOP_OFF 7
`define SCT_MR_WL_MSB 11
`define SCT_MR_WL_LSB 8

`define SCT_RAS_PS 35000
`define SCT_WR_PS 15000
`define SCT_WR_MIN_CK 4
`define SCT_XPDLL_PS 24000
`define SCT_REFPDEN_CK 1
`define SCT_RFC_PS 110000
`define SCT_REFI_PS 7812500
`define SCT_REFI_HOT_PS 3906250
`define SCT_REF_WIN_PS 70300000
`define SCT_REF_WIN_CNT 9
`define SCT_REF_PEND_MAX 8
`define SCT_SLOW_CK_PS 40000
`define SCT_LOCK_CK 512
`define SCT_PWRUP_PS 200000000
`define SCT_WR_START_LONG 4
`define SCT_WR_START_CHOP 2
`define SCT_BURST_LONG_CK 4
`define SCT_BURST_CHOP_CK 2

`define SCT_RAS_CK `SCT_CEIL_CK(`SCT_RAS_PS)
`define SCT_WR_CK `SCT_MAX(`SCT_WR_MIN_CK, `SCT_CEIL_CK(`SCT_WR_PS))
`define SCT_XPDLL_CK `SCT_CEIL_CK(`SCT_XPDLL_PS)
`define SCT_REFI_CK `SCT_FLOOR_CK(`SCT_REFI_PS)
`define SCT_REFI_HOT_CK `SCT_FLOOR_CK(`SCT_REFI_HOT_PS)
`define SCT_PWRUP_CK `SCT_CEIL_CK(`SCT_PWRUP_PS)

`endif

/* File: inc/sct_pkg.sv */
// types for the command-timing link; only the command type is used by both ends
package sct_pkg;
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACT = 3'h1,
		CMD_RD = 3'h2,
		CMD_WR = 3'h3,
		CMD_PRE = 3'h4,
		CMD_REF = 3'h5,
		CMD_MRS = 3'h6
	} sct_cmd_t;
	typedef enum logic [2:0] {
		OP_ACT = 3'h0,
		OP_RD = 3'h1,
		OP_WR = 3'h2,
		OP_MRS = 3'h3,
		OP_PDN = 3'h4,
		OP_PUP = 3'h5
	} sct_op_t;
	typedef enum logic [5:0] {
		ST_PWR = 6'h01,
		ST_LOCK = 6'h02,
		ST_IDLE = 6'h04,
		ST_WAIT = 6'h08,
		ST_REF = 6'h10,
		ST_PDN = 6'h20
	} sct_state_t;
endpackage

/* File: inc/sct_link_if.sv */
// command link between the memory controller end and the dram end
`timescale 1ns/1ns
`default_nettype none
`include "sct_defs.svh"
interface sct_link_if;
	logic mem_ck;
	logic mem_cke;
	logic mem_reset_n;
	sct_pkg::sct_cmd_t mem_cmd;
	logic mem_ap;
	logic mem_bc4;
	logic [`SCT_ADDR_W-1:0] mem_addr;
	logic mem_dqs;
	logic mem_dqs_oe;
	modport ctrl(output mem_ck, mem_cke, mem_reset_n, mem_cmd, mem_ap, mem_bc4, mem_addr,
		input mem_dqs, mem_dqs_oe);
	modport dev(input mem_ck, mem_cke, mem_reset_n, mem_cmd, mem_ap, mem_bc4, mem_addr,
		output mem_dqs, mem_dqs_oe);
endinterface
`default_nettype wire

/* File: hdl/sct_timer.sv */
// down counter in link clock ticks, used for command spacing
`timescale 1ns/1ns
`default_nettype none
module sct_timer #(
	parameter int W = 10,
	parameter int INIT = 0
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic tick, // one pulse per link clock period
	input wire logic load, // load a new count
	input wire logic [W-1:0] load_val, // count in ticks
	output logic done // count has run out
);
	logic [W-1:0] cnt_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= W'(INIT);
		end else if (load) begin
			cnt_reg <= load_val;
		end else if (tick && cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	assign done = (cnt_reg == '0);
endmodule
`default_nettype wire

/* File: hdl/sct_dev_end.sv */
// dram end: samples the link, tracks latencies, auto precharge and refreshes
`timescale 1ns/1ns
`default_nettype none
`include "sct_defs.svh"
module sct_dev_end (
	input wire logic mclk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	sct_link_if.dev link, // command link
	output logic row_open, // a row is active
	output logic auto_pre, // internal precharge done, one cycle
	output logic [15:0] ref_count // refreshes taken
);
	localparam int SW = 5 + 3 + `SCT_ADDR_W;
	localparam int CW = 8;

	logic [SW-1:0] s1_reg;
	logic [SW-1:0] s2_reg;
	logic ck_d_reg;
	logic ck_s;
	logic cke_s;
	logic rstn_s;
	logic ap_s;
	logic bc4_s;
	sct_pkg::sct_cmd_t cmd_s;
	logic [`SCT_ADDR_W-1:0] addr_s;
	logic rise;
	logic [`SCT_ADDR_W-1:0] mode_reg;
	logic [CW-1:0] ras_reg;
	logic [CW-1:0] wr_reg;
	logic [CW-1:0] rd_reg;
	logic [CW-1:0] burst_reg;
	logic [CW-1:0] lat_sum;
	logic rd_busy_reg;
	logic ap_pend_reg;
	logic dqs_reg;
	logic dqs_oe_reg;

	////////////////////////////////////////////////////////////////////////////////
	// every link input passes two flops; commands are held a whole link period
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			ck_d_reg <= 1'b0;
		end else begin
			s1_reg <= {link.mem_ck, link.mem_cke, link.mem_reset_n, link.mem_ap, link.mem_bc4,
				link.mem_cmd, link.mem_addr};
			s2_reg <= s1_reg;
			ck_d_reg <= ck_s;
		end
	end

	assign ck_s = s2_reg[SW-1];
	assign cke_s = s2_reg[SW-2];
	assign rstn_s = s2_reg[SW-3];
	assign ap_s = s2_reg[SW-4];
	assign bc4_s = s2_reg[SW-5];
	assign cmd_s = sct_pkg::sct_cmd_t'(s2_reg[`SCT_ADDR_W+2:`SCT_ADDR_W]);
	assign addr_s = s2_reg[`SCT_ADDR_W-1:0];
	assign rise = ck_s && !ck_d_reg && cke_s && rstn_s;
	assign lat_sum = CW'(mode_reg[`SCT_MR_CL_MSB:`SCT_MR_CL_LSB])
		+ CW'(mode_reg[`SCT_MR_AL_MSB:`SCT_MR_AL_LSB]);

	////////////////////////////////////////////////////////////////////////////////
	// mode, row and auto precharge state
	always_ff @(posedge mclk) begin
		if (!rst_n || !rstn_s) begin
			mode_reg <= '0;
			row_open <= 1'b0;
			auto_pre <= 1'b0;
			ap_pend_reg <= 1'b0;
			ras_reg <= '0;
			wr_reg <= '0;
		end else begin
			auto_pre <= 1'b0;
			if (rise && ras_reg != '0) begin
				ras_reg <= ras_reg - 1'b1;
			end
			if (rise && wr_reg != '0) begin
				wr_reg <= wr_reg - 1'b1;
			end
			if (rise) begin
				unique case (cmd_s)
					sct_pkg::CMD_MRS: mode_reg <= addr_s;
					sct_pkg::CMD_ACT: begin
						row_open <= 1'b1;
						ras_reg <= CW'(`SCT_RAS_CK);
					end
					sct_pkg::CMD_PRE: row_open <= 1'b0;
					sct_pkg::CMD_RD: ap_pend_reg <= ap_s;
					sct_pkg::CMD_WR: begin
						ap_pend_reg <= ap_s;
						wr_reg <= CW'(mode_reg[`SCT_MR_WL_MSB:`SCT_MR_WL_LSB])
							+ (mode_reg[`SCT_MR_BC4_FIXED] ? CW'(`SCT_WR_START_CHOP)
							: CW'(`SCT_WR_START_LONG)) + CW'(`SCT_WR_CK);
					end
					default: ;
				endcase
			end else if (ap_pend_reg && ras_reg == '0 && wr_reg == '0) begin
				// precharge held off until the row has been open long enough and write recovery has run out
				ap_pend_reg <= 1'b0;
				row_open <= 1'b0;
				auto_pre <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read strobe window; outputs stay off while the device reset is low
	always_ff @(posedge mclk) begin
		if (!rst_n || !rstn_s) begin
			rd_reg <= '0;
			rd_busy_reg <= 1'b0;
			burst_reg <= '0;
			dqs_reg <= 1'b0;
			dqs_oe_reg <= 1'b0;
		end else if (rise) begin
			if (burst_reg == 8'h01) begin
				dqs_oe_reg <= 1'b0;
				dqs_reg <= 1'b0;
			end
			if (burst_reg != '0) begin
				burst_reg <= burst_reg - 1'b1;
			end
			if (cmd_s == sct_pkg::CMD_RD) begin
				// loop off moves the window one cycle earlier
				rd_reg <= mode_reg[`SCT_MR_LOOP_OFF] ? lat_sum - 1'b1 : lat_sum;
				rd_busy_reg <= 1'b1;
			end else if (rd_busy_reg) begin
				rd_reg <= rd_reg - 1'b1;
				if (rd_reg <= 8'h01) begin
					rd_busy_reg <= 1'b0;
					dqs_oe_reg <= 1'b1;
					dqs_reg <= 1'b1;
					burst_reg <= bc4_s ? CW'(`SCT_BURST_CHOP_CK) : CW'(`SCT_BURST_LONG_CK);
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || !rstn_s) begin
			ref_count <= '0;
		end else if (rise && cmd_s == sct_pkg::CMD_REF) begin
			ref_count <= ref_count + 1'b1;
		end
	end

	assign link.mem_dqs = dqs_reg;
	assign link.mem_dqs_oe = dqs_oe_reg;
endmodule
`default_nettype wire

/* File: hdl/sct_ctrl_end.sv */
// memory controller end: makes the link clock, sequences and spaces commands
`timescale 1ns/1ns
`default_nettype none
`include "sct_defs.svh"
module sct_ctrl_end #(
	parameter int TW = 10
) (
	input wire logic mclk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic req, // user request, held until ack
	input wire sct_pkg::sct_op_t op, // requested operation
	input wire logic ap, // auto precharge with read or write
	input wire logic bc4, // on-the-fly burst chop select
	input wire logic [`SCT_ADDR_W-1:0] mode, // mode word for set and power-up
	input wire logic hot, // case temperature above 85 C
	output logic ack, // request taken, one cycle
	output logic ready, // idle and able to take a request
	output logic locked, // delay loop assumed locked
	sct_link_if.ctrl link // command link
);
	logic [2:0] div_reg;
	logic ck_reg;
	logic tick;
	sct_pkg::sct_state_t state_reg;
	sct_pkg::sct_cmd_t cmd_reg;
	logic ap_reg;
	logic bc4_reg;
	logic [`SCT_ADDR_W-1:0] addr_reg;
	logic [`SCT_ADDR_W-1:0] mode_reg;
	logic cke_reg;
	logic reset_n_reg;
	logic tmr_load_reg;
	logic [TW-1:0] tmr_val_reg;
	logic tmr_done;
	logic pdn_pend_reg;
	logic ref_step_reg;
	logic [TW-1:0] refi_reg;
	logic [3:0] pend_reg;
	logic [3:0] pend_next;
	logic ref_due;
	logic ref_issue;
	logic [TW-1:0] refi_limit;
	logic [TW-1:0] rd_wait;
	logic [TW-1:0] wr_wait;

	////////////////////////////////////////////////////////////////////////////////
	// link clock by division; commands change while the link clock is low
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			div_reg <= '0;
			ck_reg <= 1'b0;
		end else begin
			div_reg <= div_reg + 1'b1;
			ck_reg <= div_reg[2];
		end
	end

	assign tick = (div_reg == 3'h1);

	sct_timer #(
		.W(TW),
		.INIT(`SCT_PWRUP_CK)
	) u_tmr (
		.clk(mclk),
		.rst_n(rst_n),
		.tick(tick),
		.load(tmr_load_reg),
		.load_val(tmr_val_reg),
		.done(tmr_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// refresh owed counter; counts round down so the average stays inside the period
	assign refi_limit = hot ? TW'(`SCT_REFI_HOT_CK) : TW'(`SCT_REFI_CK);
	assign ref_due = tick && (refi_reg >= refi_limit - 1'b1);
	assign ref_issue = tick && state_reg == sct_pkg::ST_IDLE && pend_reg != '0;

	always_comb begin
		pend_next = pend_reg;
		// owed refreshes pile up during power-down and go out as a burst
		if (ref_due && pend_reg != 4'(`SCT_REF_PEND_MAX)) begin
			pend_next = pend_next + 1'b1;
		end
		if (ref_issue) begin
			pend_next = pend_next - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			refi_reg <= '0;
			pend_reg <= '0;
		end else begin
			pend_reg <= pend_next;
			if (ref_due) begin
				refi_reg <= '0;
			end else if (tick && state_reg != sct_pkg::ST_PWR) begin
				refi_reg <= refi_reg + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// waits after reads and writes
	assign rd_wait = TW'(mode_reg[`SCT_MR_CL_MSB:`SCT_MR_CL_LSB])
		+ TW'(mode_reg[`SCT_MR_AL_MSB:`SCT_MR_AL_LSB]) + TW'(`SCT_BURST_LONG_CK)
		+ (ap ? TW'(`SCT_RAS_CK) : '0);
	assign wr_wait = TW'(mode_reg[`SCT_MR_WL_MSB:`SCT_MR_WL_LSB])
		+ (mode_reg[`SCT_MR_BC4_FIXED] ? TW'(`SCT_WR_START_CHOP)
		: TW'(`SCT_WR_START_LONG)) + TW'(`SCT_WR_CK);

	////////////////////////////////////////////////////////////////////////////////
	// command sequencer, acting once per link period
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= sct_pkg::ST_PWR;
			cmd_reg <= sct_pkg::CMD_NOP;
			ap_reg <= 1'b0;
			bc4_reg <= 1'b0;
			addr_reg <= '0;
			mode_reg <= '0;
			cke_reg <= 1'b0;
			reset_n_reg <= 1'b0;
			tmr_load_reg <= 1'b0;
			tmr_val_reg <= '0;
			pdn_pend_reg <= 1'b0;
			ref_step_reg <= 1'b0;
			ack <= 1'b0;
			locked <= 1'b0;
		end else begin
			tmr_load_reg <= 1'b0;
			ack <= 1'b0;
			if (tick) begin
				cmd_reg <= sct_pkg::CMD_NOP;
				ap_reg <= 1'b0;
				unique case (state_reg)
					sct_pkg::ST_PWR: begin
						if (tmr_done) begin
							reset_n_reg <= 1'b1;
							cke_reg <= 1'b1;
							cmd_reg <= sct_pkg::CMD_MRS;
							addr_reg <= mode;
							mode_reg <= mode;
							tmr_load_reg <= 1'b1;
							tmr_val_reg <= TW'(`SCT_LOCK_CK);
							state_reg <= sct_pkg::ST_LOCK;
						end
					end
					sct_pkg::ST_LOCK: begin
						if (tmr_done) begin
							locked <= 1'b1;
							state_reg <= sct_pkg::ST_IDLE;
						end
					end
					sct_pkg::ST_IDLE: begin
						if (pend_reg != '0) begin
							cmd_reg <= sct_pkg::CMD_REF;
							ref_step_reg <= 1'b0;
							state_reg <= sct_pkg::ST_REF;
						end else if (req) begin
							ack <= 1'b1;
							unique case (op)
								sct_pkg::OP_ACT: cmd_reg <= sct_pkg::CMD_ACT;
								sct_pkg::OP_RD: begin
									// reads are only sent once the loop has settled
									if (locked) begin
										cmd_reg <= sct_pkg::CMD_RD;
										ap_reg <= ap;
										bc4_reg <= bc4;
										tmr_load_reg <= 1'b1;
										tmr_val_reg <= rd_wait;
										state_reg <= sct_pkg::ST_WAIT;
									end
								end
								sct_pkg::OP_WR: begin
									cmd_reg <= sct_pkg::CMD_WR;
									ap_reg <= ap;
									bc4_reg <= bc4;
									tmr_load_reg <= 1'b1;
									tmr_val_reg <= wr_wait;
									state_reg <= sct_pkg::ST_WAIT;
								end
								sct_pkg::OP_MRS: begin
									cmd_reg <= sct_pkg::CMD_MRS;
									addr_reg <= mode;
									mode_reg <= mode;
									tmr_load_reg <= 1'b1;
									// turning the loop back on needs a full relock
									if (mode_reg[`SCT_MR_LOOP_OFF] && !mode[`SCT_MR_LOOP_OFF]) begin
										tmr_val_reg <= TW'(`SCT_LOCK_CK);
									end else begin
										tmr_val_reg <= TW'(`SCT_XPDLL_CK);
									end
									state_reg <= sct_pkg::ST_WAIT;
								end
								sct_pkg::OP_PDN: begin
									pdn_pend_reg <= 1'b1;
									tmr_load_reg <= 1'b1;
									tmr_val_reg <= TW'(`SCT_REFPDEN_CK + `SCT_XPDLL_CK);
									state_reg <= sct_pkg::ST_WAIT;
								end
								default: ;
							endcase
						end
					end
					sct_pkg::ST_WAIT: begin
						if (tmr_done) begin
							if (pdn_pend_reg) begin
								pdn_pend_reg <= 1'b0;
								cke_reg <= 1'b0;
								state_reg <= sct_pkg::ST_PDN;
							end else begin
								state_reg <= sct_pkg::ST_IDLE;
							end
						end
					end
					sct_pkg::ST_REF: begin
						if (!ref_step_reg) begin
							// this slot stays a no-operation between refreshes
							ref_step_reg <= 1'b1;
						end else begin
							if (`SCT_TCK_PS > `SCT_SLOW_CK_PS) begin
								cmd_reg <= sct_pkg::CMD_PRE;
							end
							state_reg <= sct_pkg::ST_IDLE;
						end
					end
					sct_pkg::ST_PDN: begin
						if (req && op == sct_pkg::OP_PUP) begin
							ack <= 1'b1;
							cke_reg <= 1'b1;
							tmr_load_reg <= 1'b1;
							tmr_val_reg <= TW'(`SCT_XPDLL_CK);
							state_reg <= sct_pkg::ST_WAIT;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ready <= 1'b0;
		end else begin
			ready <= (state_reg == sct_pkg::ST_IDLE) && (pend_reg == '0);
		end
	end

	assign link.mem_ck = ck_reg;
	assign link.mem_cke = cke_reg;
	assign link.mem_reset_n = reset_n_reg;
	assign link.mem_cmd = cmd_reg;
	assign link.mem_ap = ap_reg;
	assign link.mem_bc4 = bc4_reg;
	assign link.mem_addr = addr_reg;
endmodule
`default_nettype wire

/* File: tb/sct_link_asserts.sv */
// concurrent checks on the command link between the two ends
`timescale 1ns/1ns
`default_nettype none
`include "sct_defs.svh"
module sct_link_asserts (
	input wire logic mclk, // system clock
	input wire logic rst_n, // sync reset, active low
	input wire logic mem_ck, // link clock
	input wire logic mem_cke, // clock enable
	input wire logic mem_reset_n, // device reset, active low
	input wire sct_pkg::sct_cmd_t mem_cmd, // command
	input wire logic mem_ap, // auto precharge
	input wire logic mem_bc4, // chop select
	input wire logic [`SCT_ADDR_W-1:0] mem_addr, // mode word
	input wire logic mem_dqs, // strobe window
	input wire logic mem_dqs_oe // strobe driven
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sct_pkg::sct_cmd_t cmd_reg;
	logic ck_reg, rn_reg;
	logic [7:0] lat_reg, gap_reg, tk_reg;
	logic [13:0] cy_reg, wr_reg, ref_reg;
	// a repeated identical command is not seen as new; the controller never does that
	wire logic iss = mem_cmd != cmd_reg && mem_cmd != sct_pkg::CMD_NOP;
	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk) begin
		cmd_reg <= mem_cmd;
		ck_reg <= mem_ck;
		rn_reg <= mem_reset_n;
		if (!rst_n || mem_reset_n != rn_reg) cy_reg <= 14'h0;
		else cy_reg <= cy_reg + {13'h0, ~&cy_reg};
	end
	// latencies follow the last mode word seen on the link
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lat_reg <= 8'h0;
			gap_reg <= 8'h0;
		end else if (iss && mem_cmd == sct_pkg::CMD_MRS) begin
			lat_reg <= 8'(mem_addr[3:0]) + 8'(mem_addr[5:4]) - 8'(mem_addr[7]);
			gap_reg <= 8'(mem_addr[11:8]) + (mem_addr[6] ? 8'h2 : 8'h4) + 8'h4;
		end
	end
	always_ff @(posedge mclk) begin
		if (!rst_n || (iss && mem_cmd == sct_pkg::CMD_RD)) tk_reg <= 8'hff;
		else if (mem_ck && !ck_reg) tk_reg <= tk_reg + 8'h1;
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) wr_reg <= 14'h3fff;
		else if (iss && mem_cmd == sct_pkg::CMD_WR) wr_reg <= 14'h0;
		else wr_reg <= wr_reg + {13'h0, ~&wr_reg};
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) ref_reg <= 14'h3fff;
		else if (iss && mem_cmd == sct_pkg::CMD_REF) ref_reg <= 14'h0;
		else ref_reg <= ref_reg + {13'h0, ~&ref_reg};
	end
	////////////////////////////////////////////////////////////////////////////
	sequence s_ref_tail;
		##8 mem_cmd == sct_pkg::CMD_NOP ##8 mem_cmd == sct_pkg::CMD_PRE;
	endsequence
	sequence s_ck_period;
		##4 $fell(mem_ck) ##4 $rose(mem_ck);
	endsequence
	property p_ref_tail;
		iss && mem_cmd == sct_pkg::CMD_REF |-> s_ref_tail;
	endproperty
	a_ref_tail: assert property (p_ref_tail)
		else $error("refresh not followed by idle then precharge all");
	property p_ck_div;
		$rose(mem_ck) |-> s_ck_period;
	endproperty
	a_ck_div: assert property (p_ck_div)
		else $error("link clock period is not eight system clocks");
	property p_strobe_at;
		$rose(mem_dqs) |-> tk_reg == lat_reg && mem_dqs_oe;
	endproperty
	a_strobe_at: assert property (p_strobe_at)
		else $error("read strobe window opened at the wrong link tick");
	property p_wr_gap;
		iss |-> wr_reg >= {3'h0, gap_reg, 3'h0};
	endproperty
	a_wr_gap: assert property (p_wr_gap)
		else $error("command issued inside write recovery");
	property p_mrs_hold;
		iss && mem_cmd == sct_pkg::CMD_MRS |-> ##1 (mem_cmd inside {sct_pkg::CMD_MRS,
			sct_pkg::CMD_NOP}) [*8];
	endproperty
	a_mrs_hold: assert property (p_mrs_hold)
		else $error("command too soon after latency change");
	property p_rd_lock;
		iss && mem_cmd == sct_pkg::CMD_RD |-> cy_reg >= 14'd4096;
	endproperty
	a_rd_lock: assert property (p_rd_lock)
		else $error("read issued before the loop lock wait");
	property p_pwrup;
		$rose(mem_reset_n) |-> cy_reg >= 14'd1992;
	endproperty
	a_pwrup: assert property (p_pwrup)
		else $error("device reset released too early");
	property p_cke_rst;
		!mem_reset_n |-> !mem_cke;
	endproperty
	a_cke_rst: assert property (p_cke_rst)
		else $error("clock enable high during device reset");
	property p_pdn_ref;
		$fell(mem_cke) |-> ref_reg >= 14'd16;
	endproperty
	a_pdn_ref: assert property (p_pdn_ref)
		else $error("power-down entered too soon after refresh");
endmodule
`default_nettype wire

/* File: tb/sct_sdram_command_timing_tb.sv */
// self-checking bench: controller end facing dram end over the link
`timescale 1ns/1ns
`default_nettype none
`include "sct_defs.svh"
module sct_sdram_command_timing_tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic req = 1'b0;
	logic ap = 1'b0;
	logic bc4 = 1'b0;
	logic hot = 1'b0;
	sct_pkg::sct_op_t op = sct_pkg::OP_ACT;
	logic [`SCT_ADDR_W-1:0] mode = 12'h505;
	logic ack, ready, locked, row_open, auto_pre, off;
	logic [15:0] ref_count, rc;
	logic [11:0] m;
	int failures = 0;
	int checks_done = 0;
	int n;
	sct_link_if link ();
	always #50 mclk = ~mclk;
	sct_ctrl_end #(.TW(10)) u_sct_ctrl_end (
		.mclk(mclk), .rst_n(rst_n), .req(req), .op(op), .ap(ap), .bc4(bc4), .mode(mode),
		.hot(hot), .ack(ack), .ready(ready), .locked(locked), .link(link.ctrl)
	);
	sct_dev_end u_sct_dev_end (
		.mclk(mclk), .rst_n(rst_n), .link(link.dev), .row_open(row_open),
		.auto_pre(auto_pre), .ref_count(ref_count)
	);
	sct_link_asserts u_sct_link_asserts (
		.mclk(mclk), .rst_n(rst_n), .mem_ck(link.mem_ck), .mem_cke(link.mem_cke),
		.mem_reset_n(link.mem_reset_n), .mem_cmd(link.mem_cmd), .mem_ap(link.mem_ap),
		.mem_bc4(link.mem_bc4), .mem_addr(link.mem_addr), .mem_dqs(link.mem_dqs),
		.mem_dqs_oe(link.mem_dqs_oe)
	);
	////////////////////////////////////////////////////////////////////////////
	function automatic int rd_lat(input logic [11:0] w);
		return int'(w[3:0]) + int'(w[5:4]) - int'(w[7]);
	endfunction
	// an on-the-fly chop still recovers from four ticks after write latency
	function automatic int wr_rec(input logic [11:0] w);
		return int'(w[11:8]) + (w[6] ? 2 : 4) + 4;
	endfunction
	function automatic logic pick(input int s);
		case (s)
			0: return ack;
			1: return ready;
			2: return locked;
			3: return auto_pre;
			default: return link.mem_dqs;
		endcase
	endfunction
	task automatic conclude();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] got);
		checks_done++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			failures++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	// sampled on the falling edge so registered outputs have settled
	task automatic wait_hi(input int s, input int lim, output int cy);
		cy = 0;
		while (pick(s) !== 1'b1) begin
			@(negedge mclk);
			cy++;
			if (cy > lim) begin
				failures++;
				$display("MISMATCH wait %0d expected high seen low", s);
				conclude();
			end
		end
	endtask
	task automatic idle();
		int cy;
		wait_hi(1, 6000, cy);
	endtask
	task automatic issue(input sct_pkg::sct_op_t o, input logic a, input logic c);
		int cy;
		@(posedge mclk);
		op <= o;
		ap <= a;
		bc4 <= c;
		req <= 1'b1;
		@(negedge mclk);
		wait_hi(0, 400, cy);
		@(posedge mclk);
		req <= 1'b0;
		@(negedge mclk);
	endtask
	task automatic power_up();
		int cy;
		wait_hi(2, 8000, cy);
		cmp("lock time", 8 * (250 + 512), 8 * (250 + 512) + 80, cy);
		idle();
		$display("test power-up done");
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hdd8113d7));
		off = 1'b0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		power_up();
		for (int i = 0; i < 4; i++) begin
			m = {4'(5 + $urandom_range(3)), ~i[0], 1'($urandom), 2'($urandom_range(2)),
				4'(5 + $urandom_range(3))};
			@(posedge mclk);
			mode <= m;
			rc = ref_count;
			issue(sct_pkg::OP_MRS, 1'b0, 1'b0);
			idle();
			// the saturated eight go out first; up to four more fall due while they drain
			if (off && !m[7]) cmp("burst refreshes", 8, 12, 32'(ref_count - rc));
			off = m[7];
			issue(sct_pkg::OP_ACT, 1'b0, 1'b0);
			idle();
			issue(sct_pkg::OP_RD, 1'b1, 1'b0);
			wait_hi(4, 400, n);
			cmp("read strobe delay", 8 * rd_lat(m), 8 * rd_lat(m) + 12, n);
			idle();
			issue(sct_pkg::OP_ACT, 1'b0, 1'b0);
			idle();
			issue(sct_pkg::OP_WR, 1'b1, 1'($urandom));
			wait_hi(3, 600, n);
			cmp("write recovery", 8 * wr_rec(m), 8 * wr_rec(m) + 16, n);
			idle();
			cmp("row closed", 0, 0, 32'(row_open));
			$display("test access %0d done", i);
		end
		@(negedge mclk);
		rc = ref_count;
		repeat (703) @(negedge mclk);
		cmp("refreshes cold", 9, 11, 32'(ref_count - rc));
		@(posedge mclk);
		hot <= 1'b1;
		@(negedge mclk);
		rc = ref_count;
		repeat (703) @(negedge mclk);
		cmp("refreshes hot", 19, 23, 32'(ref_count - rc));
		$display("test refresh done");
		idle();
		issue(sct_pkg::OP_PDN, 1'b0, 1'b0);
		repeat (40) @(negedge mclk);
		cmp("cke in power-down", 0, 0, 32'(link.mem_cke));
		issue(sct_pkg::OP_PUP, 1'b0, 1'b0);
		idle();
		cmp("cke after wake", 1, 1, 32'(link.mem_cke));
		$display("test power-down done");
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (10) @(negedge mclk);
		cmp("device reset held", 0, 0, 32'(link.mem_reset_n));
		cmp("lock cleared", 0, 0, 32'(locked));
		@(posedge mclk);
		rst_n <= 1'b1;
		power_up();
		conclude();
	end
endmodule
`default_nettype wire
